/* logic/rsc_radio_state_controller.sv */
// radio control state machine: power sequencing, calibration, sleep and wake
// How it works
// - reset command resets and shuts down device
// - chip select low does power-on reset, idle
// - chip select low in sleep wakes to idle
// - idle command works from all but off, power-on init, sleep and wake
// - idle: radio off, digital on, registers accessible
// - synth ready from idle runs full calibration
// - synth ready accepted from idle, rx, tx, cca
// - receive from synth ready, cca, transmit
// - packet mode rx returns to synth ready
// - cca from synth ready or rx, returns back
// - transmit from synth ready or receive
// - packet mode tx returns to synth ready
// - measure only from idle, ends on idle
// - sleep mode chosen by sleep config field
// - backup-only sleep loses packet and modem memory
// - oscillator sleeps keep oscillator and backup memory
// - wake timer setup cleared while sleeping
// - wake interrupt on timer wake if enabled
// - ready immediate outside sleep and off, delayed from sleep and off
// - wake timer timeout leaves crystal or RC oscillator sleep, not backup-only sleep
`timescale 1ns/1ps
module rsc_radio_state_controller
	import rsc_pkg::*;
#(
	parameter int STARTUP_WAIT = STARTUP_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic cs_n_in,
	input wire logic cmd_valid_in,
	input wire logic [2:0] cmd_code_in,
	input wire logic packet_mode_in,
	input wire logic [3:0] sleep_config_in,
	input wire logic wake_timer_expired_in,
	input wire logic wake_irq_enable_in,
	input wire logic packet_done_in,
	input wire logic [7:0] temp_sample_in,
	input wire logic wake_timer_we_in,
	input wire logic [7:0] wake_timer_setup_a_in,
	input wire logic [7:0] wake_timer_setup_b_in,
	output logic miso_ready_out,
	output logic [3:0] state_out,
	output logic digital_on_out,
	output logic synth_on_out,
	output logic rx_on_out,
	output logic tx_on_out,
	output logic calibrating_out,
	output logic osc32k_xtal_on_out,
	output logic osc32k_rc_on_out,
	output logic packet_mem_valid_out,
	output logic wake_irq_out,
	output logic [7:0] temp_reading_out,
	output logic [7:0] wake_timer_setup_a_out,
	output logic [7:0] wake_timer_setup_b_out
);
	// the start-up counter is 16 bits wide, so longer waits cannot be served
	if (STARTUP_WAIT < 1 || STARTUP_WAIT > 65535) begin : g_bad_wait
		$error("STARTUP_WAIT must lie between 1 and 65535");
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; first stage feeds only the second
	logic cs_s1_r, cs_s2_r, wk_s1_r, wk_s2_r, cs_prev_r;
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			cs_prev_r <= 1'b1;
			wk_s1_r <= 1'b0;
			wk_s2_r <= 1'b0;
		end else begin
			cs_s1_r <= cs_n_in;
			cs_s2_r <= cs_s1_r;
			cs_prev_r <= cs_s2_r;
			wk_s1_r <= wake_timer_expired_in;
			wk_s2_r <= wk_s1_r;
		end
	end
	logic cs_fall;
	assign cs_fall = cs_prev_r & ~cs_s2_r;

	////////////////////////////////////////////////////////////////////////
	// state machine: next values
	rsc_state_t state_r, state_nxt, cca_ret_r, cca_ret_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic cal_r, cal_nxt, ready_r, ready_nxt, irq_r, irq_nxt, timer_wake_r, timer_wake_nxt;
	logic mem_r, mem_nxt;
	logic [3:0] slp_r, slp_nxt;
	logic cnt_done;
	assign cnt_done = (cnt_r == 16'h0000);

	always_comb begin
		state_nxt = state_r;
		cca_ret_nxt = cca_ret_r;
		cnt_nxt = cnt_done ? cnt_r : cnt_r - 16'h0001;
		cal_nxt = cal_r;
		ready_nxt = ready_r;
		irq_nxt = irq_r;
		timer_wake_nxt = timer_wake_r;
		mem_nxt = mem_r;
		slp_nxt = slp_r;
		unique case (state_r)
			ST_OFF: begin
				if (cs_fall) begin
					state_nxt = ST_POR_INIT;
					cnt_nxt = 16'(POR_INIT_CYCLES);
				end
			end
			ST_POR_INIT: begin
				if (cnt_done) begin
					state_nxt = ST_IDLE;
					ready_nxt = 1'b1;
					mem_nxt = 1'b1;
				end
			end
			ST_SLEEP: begin
				if (cs_fall) begin
					state_nxt = ST_WAKE;
					timer_wake_nxt = 1'b0;
					cnt_nxt = 16'(STARTUP_WAIT);
				end else if (wk_s2_r && (slp_r == SLEEP_CFG_CRYSTAL || slp_r == SLEEP_CFG_RC_OSC)) begin
					state_nxt = ST_WAKE;
					timer_wake_nxt = 1'b1;
					cnt_nxt = 16'(STARTUP_WAIT);
				end
			end
			ST_WAKE: begin
				if (cnt_done) begin
					state_nxt = ST_IDLE;
					ready_nxt = 1'b1;
					irq_nxt = irq_r | (timer_wake_r & wake_irq_enable_in);
				end
			end
			ST_SYNTH_READY, ST_RECEIVE, ST_TRANSMIT, ST_CHANNEL_ASSESS: begin
				if (cal_r && cnt_done) cal_nxt = 1'b0;
				if (state_r == ST_CHANNEL_ASSESS && cnt_done) begin
					state_nxt = cca_ret_r;
				end else if ((state_r == ST_RECEIVE || state_r == ST_TRANSMIT) && packet_mode_in
						&& packet_done_in && !cal_r) begin
					state_nxt = ST_SYNTH_READY;
				end
			end
			default: ;
		endcase
		// commands, ignored where the transition is not permitted
		if (cmd_valid_in && state_r != ST_OFF && state_r != ST_POR_INIT
				&& state_r != ST_SLEEP && state_r != ST_WAKE) begin
			unique case (cmd_code_in)
				CMD_FULL_RESET: begin
					state_nxt = ST_OFF;
					ready_nxt = 1'b0;
					mem_nxt = 1'b0;
					cal_nxt = 1'b0;
				end
				CMD_GO_IDLE: begin
					state_nxt = ST_IDLE;
					cal_nxt = 1'b0;
				end
				CMD_GO_SYNTH_READY: begin
					if (state_r == ST_IDLE) begin
						state_nxt = ST_SYNTH_READY;
						cal_nxt = 1'b1;
						cnt_nxt = 16'(CAL_CYCLES);
					end else if (state_r inside {ST_RECEIVE, ST_TRANSMIT, ST_CHANNEL_ASSESS}) begin
						state_nxt = ST_SYNTH_READY;
						cal_nxt = 1'b0;
					end
				end
				CMD_GO_RECEIVE: begin
					if (state_r inside {ST_SYNTH_READY, ST_TRANSMIT, ST_CHANNEL_ASSESS}) begin
						state_nxt = ST_RECEIVE;
						cal_nxt = (state_r != ST_CHANNEL_ASSESS);
						cnt_nxt = 16'(SYNTH_CAL_CYCLES);
					end
				end
				CMD_GO_TRANSMIT: begin
					if (state_r inside {ST_SYNTH_READY, ST_RECEIVE}) begin
						state_nxt = ST_TRANSMIT;
						cal_nxt = 1'b1;
						cnt_nxt = 16'(SYNTH_CAL_CYCLES);
					end
				end
				CMD_GO_CHANNEL_ASSESS: begin
					if (state_r inside {ST_SYNTH_READY, ST_RECEIVE}) begin
						state_nxt = ST_CHANNEL_ASSESS;
						cca_ret_nxt = state_r;
						cal_nxt = 1'b0;
						cnt_nxt = 16'(CCA_CYCLES);
					end
				end
				CMD_GO_TEMP_MEASURE: begin
					if (state_r == ST_IDLE) state_nxt = ST_TEMP_MEASURE;
				end
				CMD_GO_SLEEP: begin
					state_nxt = ST_SLEEP;
					slp_nxt = sleep_config_in;
					ready_nxt = 1'b0;
					cal_nxt = 1'b0;
					if (sleep_config_in == SLEEP_CFG_BACKUP_ONLY) mem_nxt = 1'b0;
				end
				default: ;
			endcase
		end
		// ready is kept while chip select is high, rises on the fall outside off, power-on init, sleep and wake;
		// wake interrupt clears while chip select is high, except in sleep and wake
		if (cs_fall && state_r != ST_SLEEP && state_r != ST_WAKE && state_r != ST_OFF
				&& state_r != ST_POR_INIT && state_nxt != ST_OFF && state_nxt != ST_SLEEP)
			ready_nxt = 1'b1;
		if (cs_s2_r && state_r != ST_SLEEP && state_r != ST_WAKE) irq_nxt = 1'b0;
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= ST_OFF;
			cca_ret_r <= ST_SYNTH_READY;
			cnt_r <= 16'h0000;
			cal_r <= 1'b0;
			ready_r <= 1'b0;
			irq_r <= 1'b0;
			timer_wake_r <= 1'b0;
			mem_r <= 1'b0;
			slp_r <= SLEEP_CFG_BACKUP_ONLY;
		end else begin
			state_r <= state_nxt;
			cca_ret_r <= cca_ret_nxt;
			cnt_r <= cnt_nxt;
			cal_r <= cal_nxt;
			ready_r <= ready_nxt;
			irq_r <= irq_nxt;
			timer_wake_r <= timer_wake_nxt;
			mem_r <= mem_nxt;
			slp_r <= slp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wake timer setup and temperature reading
	logic [7:0] wta_r, wta_nxt, wtb_r, wtb_nxt, temp_r, temp_nxt;
	always_comb begin
		wta_nxt = wta_r;
		wtb_nxt = wtb_r;
		temp_nxt = temp_r;
		if (state_r == ST_SLEEP) begin
			wta_nxt = WAKE_TIMER_SETUP_RESET;
			wtb_nxt = WAKE_TIMER_SETUP_RESET;
		end else if (wake_timer_we_in && state_r == ST_IDLE) begin
			wta_nxt = wake_timer_setup_a_in;
			wtb_nxt = wake_timer_setup_b_in;
		end
		if (state_r == ST_TEMP_MEASURE) temp_nxt = temp_sample_in;
	end
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wta_r <= WAKE_TIMER_SETUP_RESET;
			wtb_r <= WAKE_TIMER_SETUP_RESET;
			temp_r <= TEMP_READING_RESET;
		end else begin
			wta_r <= wta_nxt;
			wtb_r <= wtb_nxt;
			temp_r <= temp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs decoded from state or driven straight from registers
	logic in_radio;
	assign in_radio = state_r inside {ST_SYNTH_READY, ST_RECEIVE, ST_TRANSMIT, ST_CHANNEL_ASSESS};
	assign miso_ready_out = ready_r;
	assign state_out = state_r;
	assign digital_on_out = !(state_r inside {ST_OFF, ST_SLEEP});
	assign synth_on_out = in_radio;
	// radio paths wait for synthesiser calibration before powering
	assign rx_on_out = (state_r == ST_RECEIVE || state_r == ST_CHANNEL_ASSESS) && !cal_r;
	assign tx_on_out = (state_r == ST_TRANSMIT) && !cal_r;
	assign calibrating_out = cal_r;
	assign osc32k_xtal_on_out = (state_r == ST_SLEEP) && (slp_r == SLEEP_CFG_CRYSTAL);
	assign osc32k_rc_on_out = (state_r == ST_SLEEP) && (slp_r == SLEEP_CFG_RC_OSC);
	assign packet_mem_valid_out = mem_r;
	assign wake_irq_out = irq_r;
	assign temp_reading_out = temp_r;
	assign wake_timer_setup_a_out = wta_r;
	assign wake_timer_setup_b_out = wtb_r;

	////////////////////////////////////////////////////////////////////////
	// assertions
	property p_reset_off;
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(cmd_valid_in && cmd_code_in == CMD_FULL_RESET && state_r inside {ST_IDLE, ST_RECEIVE})
			|=> (state_r == ST_OFF && !miso_ready_out);
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("reset command did not shut down");
	property p_por;
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == ST_OFF && cs_fall) |=> (state_r == ST_POR_INIT) ##[1:20] (state_r == ST_IDLE && miso_ready_out);
	endproperty
	a_por: assert property (p_por) else $error("power-on reset did not reach idle");
	property p_idle_radio_off;
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == ST_IDLE || state_r == ST_TEMP_MEASURE) |-> (!rx_on_out && !tx_on_out && digital_on_out);
	endproperty
	a_idle_radio_off: assert property (p_idle_radio_off) else $error("radio on in idle or measure");
	property p_cal_from_idle;
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == ST_IDLE && cmd_valid_in && cmd_code_in == CMD_GO_SYNTH_READY)
			|=> (calibrating_out && synth_on_out)[*8];
	endproperty
	a_cal_from_idle: assert property (p_cal_from_idle) else $error("no calibration from idle");
	property p_cca_return;
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == ST_RECEIVE && cmd_valid_in && cmd_code_in == CMD_GO_CHANNEL_ASSESS)
			|=> (state_r == ST_CHANNEL_ASSESS) ##[1:9] (state_r == ST_RECEIVE);
	endproperty
	a_cca_return: assert property (p_cca_return) else $error("assessment did not return");
	property p_temp_measure_state_only_idle;
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r != ST_IDLE && state_r != ST_TEMP_MEASURE) |=> (state_r != ST_TEMP_MEASURE);
	endproperty
	a_temp_measure_state_only_idle: assert property (p_temp_measure_state_only_idle) else $error("measure entered illegally");
	property p_sleep_clear;
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == ST_SLEEP) |=> (wake_timer_setup_a_out == 8'h00 && wake_timer_setup_b_out == 8'h00);
	endproperty
	a_sleep_clear: assert property (p_sleep_clear) else $error("wake timer setup kept in sleep");
	property p_illegal_ignored;
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == ST_IDLE && cmd_valid_in && cmd_code_in == CMD_GO_TRANSMIT) |=> (state_r == ST_IDLE);
	endproperty
	a_illegal_ignored: assert property (p_illegal_ignored) else $error("illegal command acted on");
endmodule : rsc_radio_state_controller

/* logic/rsc_pkg.sv */
// shared constants and types for the radio state controller
package rsc_pkg;
	// command codes presented on the command port
	localparam logic [2:0] CMD_FULL_RESET = 3'h0;
	localparam logic [2:0] CMD_GO_IDLE = 3'h1;
	localparam logic [2:0] CMD_GO_SYNTH_READY = 3'h2;
	localparam logic [2:0] CMD_GO_RECEIVE = 3'h3;
	localparam logic [2:0] CMD_GO_TRANSMIT = 3'h4;
	localparam logic [2:0] CMD_GO_CHANNEL_ASSESS = 3'h5;
	localparam logic [2:0] CMD_GO_TEMP_MEASURE = 3'h6;
	localparam logic [2:0] CMD_GO_SLEEP = 3'h7;
	// sleep configuration field values
	localparam logic [3:0] SLEEP_CFG_BACKUP_ONLY = 4'h1;
	localparam logic [3:0] SLEEP_CFG_CRYSTAL = 4'h5;
	localparam logic [3:0] SLEEP_CFG_RC_OSC = 4'hb;
	// values after reset
	localparam logic [7:0] WAKE_TIMER_SETUP_RESET = 8'h00;
	localparam logic [7:0] TEMP_READING_RESET = 8'h00;
	// cycle counts (10 MHz clock)
	localparam int CLK_HZ = 10000000;
	localparam int POR_INIT_CYCLES = 16;
	localparam int CAL_CYCLES = 32;
	localparam int SYNTH_CAL_CYCLES = 8;
	localparam int CCA_CYCLES = 8;
	localparam int STARTUP_US = 100;
	localparam int STARTUP_CYCLES = (STARTUP_US * (CLK_HZ / 1000000) > 0) ? STARTUP_US * (CLK_HZ / 1000000) : 1;
	// radio controller states, gray coded along the power-up path
	typedef enum logic [3:0] {
		ST_OFF = 4'h0,
		ST_POR_INIT = 4'h1,
		ST_IDLE = 4'h3,
		ST_SYNTH_READY = 4'h2,
		ST_RECEIVE = 4'h6,
		ST_TRANSMIT = 4'h7,
		ST_CHANNEL_ASSESS = 4'h5,
		ST_TEMP_MEASURE = 4'h4,
		ST_SLEEP = 4'hc,
		ST_WAKE = 4'hd
	} rsc_state_t;
endpackage : rsc_pkg

/* dv/rsc_host_model.sv */
// host side model: chip select and one-cycle 3-bit command strobes
`timescale 1ns/1ps
module rsc_host_model (
	input wire logic clk_in,
	input wire logic ready_in,
	output logic cs_n_out,
	output logic cmd_valid_out,
	output logic [2:0] cmd_code_out
);
	////////////////////////////////////////////////////////////
	// quiet levels from time zero, chip select released
	initial begin
		cs_n_out = 1'b1;
		cmd_valid_out = 1'b0;
		cmd_code_out = 3'h0;
	end
	// one-cycle strobe; code scrambled after so a missed valid shows
	task automatic send(input logic [2:0] code);
		@(posedge clk_in);
		cmd_valid_out <= 1'b1;
		cmd_code_out <= code;
		@(posedge clk_in);
		cmd_valid_out <= 1'b0;
		cmd_code_out <= ~code;
	endtask : send
	// select low, then no access until ready, bounded so a dead part cannot hang us
	task automatic wake(output int waited);
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		waited = 0;
		while (ready_in !== 1'b1 && waited < 2000) begin
			@(posedge clk_in);
			#1;
			waited++;
		end
	endtask : wake
	// deselect between sessions
	task automatic release_cs();
		@(posedge clk_in);
		cs_n_out <= 1'b1;
	endtask : release_cs
endmodule : rsc_host_model

/* dv/rsc_radio_state_controller_tb.sv */
// self-checking bench for the radio state controller
`timescale 1ns/1ps
module rsc_radio_state_controller_tb;
	import rsc_pkg::*;
	localparam int SW = 4;
	logic ref_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic cs_n, cmd_valid, ready, digital_on, synth_on, rx_on, tx_on, cal, xtal_on, rc_on, pmem, irq;
	logic [2:0] cmd_code;
	logic [3:0] state;
	logic packet_mode = 1'b0, timer_exp = 1'b0, irq_en = 1'b0, pkt_done = 1'b0, timer_we = 1'b0;
	logic [3:0] sleep_cfg = 4'h1;
	logic [7:0] temp = 8'h00, set_a = 8'h00, set_b = 8'h00, temp_out, set_a_out, set_b_out;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int w;
	////////////////////////////////////////////////////////////
	// 10 MHz clock and two-cycle reset
	always #50 ref_clk_in = ~ref_clk_in;
	initial begin
		repeat (2) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
	end
	rsc_host_model u_rsc_host_model (.clk_in(ref_clk_in), .ready_in(ready), .cs_n_out(cs_n),
		.cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code));
	rsc_radio_state_controller #(.STARTUP_WAIT(SW)) u_rsc_radio_state_controller (
		.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .cs_n_in(cs_n), .cmd_valid_in(cmd_valid),
		.cmd_code_in(cmd_code), .packet_mode_in(packet_mode), .sleep_config_in(sleep_cfg),
		.wake_timer_expired_in(timer_exp), .wake_irq_enable_in(irq_en), .packet_done_in(pkt_done),
		.temp_sample_in(temp), .wake_timer_we_in(timer_we), .wake_timer_setup_a_in(set_a),
		.wake_timer_setup_b_in(set_b), .miso_ready_out(ready), .state_out(state), .digital_on_out(digital_on),
		.synth_on_out(synth_on), .rx_on_out(rx_on), .tx_on_out(tx_on), .calibrating_out(cal),
		.osc32k_xtal_on_out(xtal_on), .osc32k_rc_on_out(rc_on), .packet_mem_valid_out(pmem),
		.wake_irq_out(irq), .temp_reading_out(temp_out), .wake_timer_setup_a_out(set_a_out),
		.wake_timer_setup_b_out(set_b_out));
	////////////////////////////////////////////////////////////
	// comparison helpers; settle 1 ns past the edge so flops have landed
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic chk1(input string what, input logic seen, input logic exp);
		check(what, {7'h00, seen}, {7'h00, exp});
	endtask : chk1
	task automatic chk_st(input rsc_state_t exp);
		check("state", {4'h0, state}, {4'h0, exp});
	endtask : chk_st
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : tick
	task automatic cmd(input logic [2:0] c, input rsc_state_t exp);
		u_rsc_host_model.send(c);
		tick(1);
		chk_st(exp);
	endtask : cmd
	task automatic pulse_done();
		@(posedge ref_clk_in);
		pkt_done <= 1'b1;
		@(posedge ref_clk_in);
		pkt_done <= 1'b0;
		tick(2);
	endtask : pulse_done
	////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_cold();
		u_rsc_host_model.wake(w);
		chk_st(ST_IDLE);
		chk1("wait", w <= 25, 1'b1);
		chk1("digital", digital_on, 1'b1);
		chk1("ready", ready, 1'b1);
		chk1("pmem", pmem, 1'b1);
		chk1("radio", rx_on | tx_on, 1'b0);
		u_rsc_host_model.release_cs();
		$display("test cold start done");
	endtask : t_cold
	task automatic t_radio();
		cmd(CMD_GO_SYNTH_READY, ST_SYNTH_READY);
		chk1("synth", synth_on, 1'b1);
		tick(31);
		chk1("cal", cal, 1'b1);
		tick(1);
		chk1("cal", cal, 1'b0);
		@(posedge ref_clk_in);
		packet_mode <= 1'b1;
		cmd(CMD_GO_RECEIVE, ST_RECEIVE);
		chk1("rx", rx_on, 1'b0);
		chk1("cal", cal, 1'b1);
		tick(10);
		chk1("rx", rx_on, 1'b1);
		pulse_done();
		chk_st(ST_SYNTH_READY);
		chk1("cal", cal, 1'b0);
		@(posedge ref_clk_in);
		packet_mode <= 1'b0;
		cmd(CMD_GO_TRANSMIT, ST_TRANSMIT);
		tick(11);
		pulse_done();
		chk_st(ST_TRANSMIT);
		chk1("tx", tx_on, 1'b1);
		cmd(CMD_GO_TEMP_MEASURE, ST_TRANSMIT);
		cmd(CMD_GO_CHANNEL_ASSESS, ST_TRANSMIT);
		cmd(CMD_GO_RECEIVE, ST_RECEIVE);
		cmd(CMD_GO_CHANNEL_ASSESS, ST_CHANNEL_ASSESS);
		tick(12);
		chk_st(ST_RECEIVE);
		cmd(CMD_GO_SYNTH_READY, ST_SYNTH_READY);
		chk1("cal", cal, 1'b0);
		$display("test radio path done");
	endtask : t_radio
	task automatic t_temp_measure_state();
		cmd(CMD_GO_TEMP_MEASURE, ST_SYNTH_READY);
		cmd(CMD_GO_IDLE, ST_IDLE);
		chk1("synth", synth_on, 1'b0);
		cmd(CMD_GO_TRANSMIT, ST_IDLE);
		@(posedge ref_clk_in);
		temp <= 8'h5a;
		cmd(CMD_GO_TEMP_MEASURE, ST_TEMP_MEASURE);
		tick(2);
		check("temp", temp_out, 8'h5a);
		chk1("radio", rx_on | tx_on, 1'b0);
		@(posedge ref_clk_in);
		temp <= 8'ha3;
		tick(3);
		check("temp", temp_out, 8'ha3);
		cmd(CMD_GO_IDLE, ST_IDLE);
		$display("test measurement done");
	endtask : t_temp_measure_state
	task automatic t_sleep(input logic [3:0] cfg);
		logic seen;
		@(posedge ref_clk_in);
		timer_we <= 1'b1;
		set_a <= 8'h3c;
		set_b <= 8'hc3;
		@(posedge ref_clk_in);
		timer_we <= 1'b0;
		tick(1);
		check("setup_b", set_b_out, 8'hc3);
		@(posedge ref_clk_in);
		sleep_cfg <= cfg;
		irq_en <= 1'b1;
		cmd(CMD_GO_SLEEP, ST_SLEEP);
		tick(1);
		check("setup_a", set_a_out, 8'h00);
		check("setup_b", set_b_out, 8'h00);
		chk1("xtal", xtal_on, cfg == 4'h5);
		chk1("rcosc", rc_on, cfg == 4'hb);
		cmd(CMD_GO_IDLE, ST_SLEEP);
		if (cfg == 4'h1) begin
			chk1("pmem", pmem, 1'b0);
			@(posedge ref_clk_in);
			timer_exp <= 1'b1;
			tick(10);
			chk_st(ST_SLEEP);
			@(posedge ref_clk_in);
			timer_exp <= 1'b0;
			u_rsc_host_model.wake(w);
			chk_st(ST_IDLE);
			chk1("delay", w >= SW + 1 && w <= SW + 10, 1'b1);
			u_rsc_host_model.release_cs();
		end else begin
			seen = 1'b0;
			@(posedge ref_clk_in);
			timer_exp <= 1'b1;
			repeat (40) begin
				tick(1);
				if (irq === 1'b1) seen = 1'b1;
			end
			@(posedge ref_clk_in);
			timer_exp <= 1'b0;
			chk1("irq", seen, 1'b1);
			chk_st(ST_IDLE);
		end
		$display("test sleep mode %h done", cfg);
	endtask : t_sleep
	task automatic t_reset();
		cmd(CMD_FULL_RESET, ST_OFF);
		tick(1);
		chk1("digital", digital_on, 1'b0);
		t_cold();
		$display("test full reset done");
	endtask : t_reset
	////////////////////////////////////////////////////////////
	// verdict, reached from the main sequence or the cycle ceiling
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	// the whole run needs well under a thousand cycles
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			wrap_up();
		end
	end
	// main sequence
	initial begin
		tick(4);
		t_cold();
		t_radio();
		t_temp_measure_state();
		t_sleep(SLEEP_CFG_BACKUP_ONLY);
		t_sleep(SLEEP_CFG_CRYSTAL);
		t_sleep(SLEEP_CFG_RC_OSC);
		t_reset();
		wrap_up();
	end
endmodule : rsc_radio_state_controller_tb
